/* bench/blrc_props.sv */
// checker: bus timing and output relations of the control bank
`timescale 1ns/1ps
module blrc_props (
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        boost_undervolt,
	input wire logic        reg1_undervolt,
	input wire logic        boost_feedback_sink_two,
	input wire logic [1:0]  boost_range,
	input wire logic        reg1_on,
	input wire logic        reg1_discharge,
	input wire logic        device_reset_req,
	input wire logic        irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	logic        wr_tk;
	logic [31:0] bc_addr;
	assign wr_tk   = hsel & htrans[1] & hready & hwrite;
	assign bc_addr = {14'h0, blrc_pkg::IDX_BOOST_CTRL, 2'h0};
	// ==============================================
	// bus timing
	sequence s_rd_taken;
		hsel && htrans[1] && hready && !hwrite;
	endsequence
	sequence s_rd_wait;
		!hreadyout ##1 hreadyout;
	endsequence
	property p_rd_wait;
		s_rd_taken |=> s_rd_wait;
	endproperty
	a_rd_wait: assert property (p_rd_wait) else $error("read data phase not one wait cycle");
	property p_wr_nowait;
		wr_tk |=> hreadyout;
	endproperty
	a_wr_nowait: assert property (p_wr_nowait) else $error("write data phase stalled");
	property p_okay;
		!hresp;
	endproperty
	a_okay: assert property (p_okay) else $error("response not okay");
	// ==============================================
	// fields and outputs
	property p_range_legal;
		boost_range != 2'h3;
	endproperty
	a_range_legal: assert property (p_range_legal) else $error("reserved range code held");
	property p_range_wr;
		$changed(boost_range) |-> $past(wr_tk, 3) && $past(haddr, 3) == bc_addr;
	endproperty
	a_range_wr: assert property (p_range_wr) else $error("range changed without a write");
	property p_fb_wr;
		$changed(boost_feedback_sink_two) |-> $past(wr_tk, 3) && $past(haddr, 3) == bc_addr;
	endproperty
	a_fb_wr: assert property (p_fb_wr) else $error("feedback changed without a write");
	property p_discharge;
		reg1_discharge |-> !reg1_on;
	endproperty
	a_discharge: assert property (p_discharge) else $error("discharge while regulator on");
	property p_rst_pulse;
		device_reset_req |=> !device_reset_req;
	endproperty
	a_rst_pulse: assert property (p_rst_pulse) else $error("reset request longer than a cycle");
	property p_rst_cause;
		$rose(device_reset_req) |-> $past(boost_undervolt, 2) || $past(reg1_undervolt, 2);
	endproperty
	a_rst_cause: assert property (p_rst_cause) else $error("reset request without undervoltage");
	property p_irq_clear;
		$fell(irq) |-> $past(wr_tk, 3);
	endproperty
	a_irq_clear: assert property (p_irq_clear) else $error("interrupt dropped without a write");
endmodule

bind blrc_top blrc_props u_props (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .boost_undervolt(boost_undervolt),
	.reg1_undervolt(reg1_undervolt), .boost_feedback_sink_two(boost_feedback_sink_two),
	.boost_range(boost_range), .reg1_on(reg1_on), .reg1_discharge(reg1_discharge),
	.device_reset_req(device_reset_req), .irq(irq));

/* bench/tb_blrc_top.sv */
// testbench: registers, hardware control, sleep, interrupts and reset of the control bank
`timescale 1ns/1ps
module tb_blrc_top;
	localparam logic [15:0] BC  = blrc_pkg::IDX_BOOST_CTRL;
	localparam logic [15:0] BS  = blrc_pkg::IDX_BOOST_SLEEP;
	localparam logic [15:0] RC  = blrc_pkg::IDX_REG1_CTRL;
	localparam logic [15:0] SK  = blrc_pkg::IDX_SECURITY;
	localparam logic [15:0] AX  = blrc_pkg::IDX_AUX;
	localparam logic [15:0] ST  = blrc_pkg::IDX_IRQ_STATUS;
	localparam logic [15:0] MK  = blrc_pkg::IDX_IRQ_MASK;
	localparam logic [31:0] KEY = {16'h0, blrc_pkg::USER_KEY};
	typedef struct {
		logic [15:0] idx;
		logic [31:0] wd;
		logic [31:0] rd;
		logic [1:0]  rng;
		logic        fb;
	} blrc_row_s;
	logic        clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0, sleep_state = 1'b0;
	logic        hw_ctrl_one = 1'b0, hw_ctrl_two = 1'b0;
	logic [1:0]  uv = 2'h0, htrans = 2'h0, boost_range;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, v;
	logic        hreadyout, hresp, boost_on, boost_feedback_sink_two, reg1_on, reg1_low_power, reg1_discharge;
	logic        reg1_switch_mode, reg1_low_power_20ma, device_reset_req, irq;
	logic [4:0]  reg1_vsel;
	int          failures = 0, check_count = 0, resets = 0;
	blrc_row_s   rows [13] = '{
		'{BC, 32'hd90d, 32'hd905, 2'h1, 1'b1}, '{SK, KEY, 32'h0001, 2'h1, 1'b1},
		'{BC, 32'h0009, 32'h0009, 2'h2, 1'b1}, '{BC, 32'h000c, 32'h0008, 2'h2, 1'b0},
		'{SK, KEY, 32'h0001, 2'h2, 1'b0}, '{BC, 32'h000c, 32'h0008, 2'h2, 1'b0},
		'{SK, KEY, 32'h0001, 2'h2, 1'b0}, '{BC, 32'h0000, 32'h0000, 2'h0, 1'b0},
		'{RC, 32'hffff, 32'hdfc1, 2'h0, 1'b0}, '{BS, 32'hffff, 32'h0100, 2'h0, 1'b0},
		'{AX, 32'hffff, 32'h3ff7, 2'h0, 1'b0}, '{16'h407f, 32'hffff, 32'h0000, 2'h0, 1'b0},
		'{MK, 32'hffff, 32'h0003, 2'h0, 1'b0}};
	blrc_top uut (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .hw_ctrl_one(hw_ctrl_one), .hw_ctrl_two(hw_ctrl_two), .sleep_state(sleep_state),
		.boost_undervolt(uv[0]), .reg1_undervolt(uv[1]), .boost_on(boost_on),
		.boost_feedback_sink_two(boost_feedback_sink_two), .boost_range(boost_range), .reg1_on(reg1_on),
		.reg1_low_power(reg1_low_power), .reg1_vsel(reg1_vsel), .reg1_discharge(reg1_discharge),
		.reg1_switch_mode(reg1_switch_mode), .reg1_low_power_20ma(reg1_low_power_20ma),
		.device_reset_req(device_reset_req), .irq(irq));
	always #25 clk = ~clk;
	always @(posedge clk) if (device_reset_req === 1'b1) resets <= resets + 1;
	// ==============================================
	// tasks
	task automatic results();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic wait_rdy();
		int n;
		n = 0;
		@(negedge clk);
		while (hreadyout !== 1'b1 && n < 20) begin
			n++;
			@(negedge clk);
		end
		if (n >= 20) begin
			failures++;
			results();
		end
		@(posedge clk);
	endtask
	task automatic ahb(input logic wr, input logic [15:0] idx, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge clk);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= {14'h0, idx, 2'h0};
		hwrite <= wr;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
	endtask
	task automatic wr(input logic [15:0] i, input logic [31:0] d);
		logic [31:0] x;
		ahb(1'b1, i, d, x);
	endtask
	task automatic rd(input logic [15:0] i, output logic [31:0] r);
		ahb(1'b0, i, 32'h0, r);
	endtask
	// ==============================================
	// main sequence
	initial begin
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		foreach (rows[i]) begin
			wr(rows[i].idx, rows[i].wd);
			rd(rows[i].idx, v);
			chk(v, rows[i].rd);
			chk(boost_range, rows[i].rng);
			chk(boost_feedback_sink_two, rows[i].fb);
		end
		$display("register rows done");
		wr(RC, 32'h0041);
		wr(AX, 32'h2aa3);
		tick(3);
		chk({reg1_on, reg1_vsel, reg1_low_power, reg1_discharge, boost_on}, {1'b1, 5'h0a, 3'h1});
		chk({reg1_switch_mode, reg1_low_power_20ma}, 2'h3);
		wr(AX, 32'h2aa1);
		tick(3);
		chk({reg1_on, reg1_discharge}, 2'h1);
		wr(RC, 32'h00c1);
		tick(3);
		chk(reg1_discharge, 1'b0);
		wr(AX, 32'h2aa3);
		hw_ctrl_one <= 1'b1;
		for (int m = 0; m < 4; m++) begin
			wr(RC, 32'h0c00 | (m << 8));
			tick(6);
			chk({reg1_on, reg1_low_power, reg1_discharge, reg1_vsel}, {m != 1, m != 3, m == 1, 5'h15});
		end
		wr(AX, 32'h2aa7);
		tick(3);
		chk(reg1_low_power, 1'b1);
		wr(AX, 32'h2aa3);
		for (int s = 0; s < 4; s++) begin
			wr(RC, (s << 11) | 32'h0100);
			tick(3);
			chk({reg1_on, reg1_vsel}, {s[0] == 1'b0, 5'h0a});
		end
		hw_ctrl_one <= 1'b0;
		hw_ctrl_two <= 1'b1;
		tick(6);
		for (int s = 0; s < 4; s++) begin
			wr(BC, (s << 11) | 32'h0100);
			tick(3);
			chk(boost_on, s[1] == 1'b0);
		end
		wr(BC, 32'h1800);
		tick(3);
		chk(boost_on, 1'b1);
		hw_ctrl_two <= 1'b0;
		sleep_state <= 1'b1;
		tick(6);
		chk(boost_on, 1'b1);
		wr(BS, 32'h0000);
		tick(3);
		chk(boost_on, 1'b0);
		sleep_state <= 1'b0;
		wr(BS, 32'h0100);
		$display("control tests done");
		for (int k = 0; k < 8; k++) begin
			wr(k[2] ? RC : BC, (k & 3) << 14);
			wr(AX, 32'h2aa0);
			wr(AX, 32'h2aa3);
			resets = 0;
			uv[k[2]] <= 1'b1;
			tick(8);
			uv <= 2'h0;
			tick(4);
			chk(resets, (k & 3) == 2);
			chk(k[2] ? reg1_on : boost_on, (k & 3) != 1);
			chk(irq, 1'b1);
			rd(ST, v);
			chk(v, 1 << k[2]);
			wr(ST, 32'h0003);
			tick(3);
			chk(irq, 1'b0);
		end
		wr(MK, 32'h0000);
		uv <= 2'h1;
		tick(8);
		uv <= 2'h0;
		tick(4);
		chk(irq, 1'b0);
		rd(ST, v);
		chk(v, 32'h1);
		wr(MK, 32'h0001);
		tick(3);
		chk(irq, 1'b1);
		wr(ST, 32'h0001);
		tick(3);
		chk(irq, 1'b0);
		$display("interrupt tests done");
		rst_b <= 1'b0;
		tick(2);
		chk({boost_range, reg1_low_power, reg1_discharge, boost_on, reg1_on, irq, hreadyout, hresp}, 9'h0e2);
		rst_b <= 1'b1;
		rd(BC, v);
		chk(v, 32'h0104);
		rd(RC, v);
		chk(v, 32'h0200);
		rd(BS, v);
		chk(v, 32'h0000);
		$display("reset test done");
		results();
	end
endmodule

/* hw/blrc_pkg.sv */
// package: register map, field layout and reset values of the boost and regulator-one control bank
package blrc_pkg;
	// ==============================================
	// register indices, byte address is four times the index
	localparam logic [15:0] IDX_BOOST_CTRL  = 16'h4064;
	localparam logic [15:0] IDX_BOOST_SLEEP = 16'h4065;
	localparam logic [15:0] IDX_REG1_CTRL   = 16'h4068;
	localparam logic [15:0] IDX_SECURITY    = 16'h4070;
	localparam logic [15:0] IDX_AUX         = 16'h4071;
	localparam logic [15:0] IDX_IRQ_STATUS  = 16'h4072;
	localparam logic [15:0] IDX_IRQ_MASK    = 16'h4073;
	localparam logic [15:0] USER_KEY        = 16'h9c5e;
	// ==============================================
	// boost, sleep and regulator one register field positions
	localparam int F_ACT_LO  = 14;
	localparam int F_SRC_LO  = 11;
	localparam int F_RANGE   = 2;
	localparam int F_B_MODE  = 8;
	localparam int F_FB      = 0;
	localparam int F_SLPENA  = 8;
	localparam int F_VCHOICE = 10;
	localparam int F_R_MODE  = 8;
	localparam int F_FLOAT   = 7;
	localparam int F_SWITCH  = 6;
	localparam int F_LPLVL   = 0;
	// aux register fields
	localparam int F_B_EN    = 0;
	localparam int F_R_EN    = 1;
	localparam int F_ONMODE  = 2;
	localparam int F_ONV_LO  = 4;
	localparam int F_SLV_LO  = 9;
	// status and mask bits
	localparam int EV_BOOST  = 0;
	localparam int EV_REG1   = 1;
	// ==============================================
	// codes and reset values
	localparam logic [1:0] ACT_IGNORE   = 2'h0;
	localparam logic [1:0] ACT_SHUTDOWN = 2'h1;
	localparam logic [1:0] ACT_RESET    = 2'h2;
	localparam logic [1:0] RANGE_RSVD   = 2'h3;
	localparam logic [1:0] RMODE_OFF    = 2'h1;
	localparam logic [1:0] RMODE_ONSET  = 2'h3;
	localparam logic [1:0] RST_RANGE    = 2'h1;
	localparam logic       RST_B_MODE   = 1'b1;
	localparam logic [1:0] RST_R_MODE   = 2'h2;
endpackage

/* hw/blrc_top.sv */
// module: boost converter and regulator-one control bank behind an ahb-lite slave
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ps

module blrc_top (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        hw_ctrl_one,
	input  wire logic        hw_ctrl_two,
	input  wire logic        sleep_state,
	input  wire logic        boost_undervolt,
	input  wire logic        reg1_undervolt,
	output logic             boost_on,
	output logic             boost_feedback_sink_two,
	output logic      [1:0]  boost_range,
	output logic             reg1_on,
	output logic             reg1_low_power,
	output logic      [4:0]  reg1_vsel,
	output logic             reg1_discharge,
	output logic             reg1_switch_mode,
	output logic             reg1_low_power_20ma,
	output logic             device_reset_req,
	output logic             irq
);
	// ==============================================
	// helpers
	function automatic logic [31:0] byte_addr(input logic [15:0] idx);
		byte_addr = {14'h0000, idx, 2'h0};
	endfunction
	function automatic logic src_active(input logic [1:0] src, input logic one, input logic two);
		src_active = (src[0] & one) | (src[1] & two);
	endfunction
	// ==============================================
	// pin synchronisers with agreement filter
	logic [4:0] pin_raw;
	logic [4:0] s1_q;
	logic [4:0] s2_q;
	logic [4:0] s3_q;
	logic [4:0] pin_q;
	logic [4:0] pin_prev_q;
	assign pin_raw = {reg1_undervolt, boost_undervolt, sleep_state, hw_ctrl_two, hw_ctrl_one};
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s1_q       <= 5'h00;
			s2_q       <= 5'h00;
			s3_q       <= 5'h00;
			pin_q      <= 5'h00;
			pin_prev_q <= 5'h00;
		end else begin
			s1_q       <= pin_raw;
			s2_q       <= s1_q;
			s3_q       <= s2_q;
			pin_q      <= (s2_q & s3_q) | (pin_q & (s2_q ^ s3_q));
			pin_prev_q <= pin_q;
		end
	end
	logic hw_one;
	logic hw_two;
	logic in_sleep;
	logic boost_uv_rise;
	logic reg1_uv_rise;
	assign hw_one        = pin_q[0];
	assign hw_two        = pin_q[1];
	assign in_sleep      = pin_q[2];
	assign boost_uv_rise = pin_q[3] & ~pin_prev_q[3];
	assign reg1_uv_rise  = pin_q[4] & ~pin_prev_q[4];
	// ==============================================
	// ahb-lite slave: writes zero-wait, reads one wait state
	logic [31:0] addr_q;
	logic        wr_q;
	logic        rd_q;
	logic        accept;
	assign accept = hsel & htrans[1] & hready;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			addr_q    <= 32'h0000_0000;
			wr_q      <= 1'b0;
			rd_q      <= 1'b0;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			if (accept) begin
				addr_q <= haddr;
			end
			wr_q      <= accept & hwrite;
			rd_q      <= accept & ~hwrite;
			hreadyout <= ~(accept & ~hwrite);
			hresp     <= 1'b0;
		end
	end
	logic wr_boost;
	logic wr_sleep;
	logic wr_reg1;
	logic wr_sec;
	logic wr_aux;
	logic wr_stat;
	logic wr_mask;
	assign wr_boost = wr_q & (addr_q == byte_addr(blrc_pkg::IDX_BOOST_CTRL));
	assign wr_sleep = wr_q & (addr_q == byte_addr(blrc_pkg::IDX_BOOST_SLEEP));
	assign wr_reg1  = wr_q & (addr_q == byte_addr(blrc_pkg::IDX_REG1_CTRL));
	assign wr_sec   = wr_q & (addr_q == byte_addr(blrc_pkg::IDX_SECURITY));
	assign wr_aux   = wr_q & (addr_q == byte_addr(blrc_pkg::IDX_AUX));
	assign wr_stat  = wr_q & (addr_q == byte_addr(blrc_pkg::IDX_IRQ_STATUS));
	assign wr_mask  = wr_q & (addr_q == byte_addr(blrc_pkg::IDX_IRQ_MASK));
	// ==============================================
	// boost control fields
	logic [1:0] boost_fault_action_q;
	logic [1:0] boost_hw_ctrl_source_q;
	logic       boost_hw_ctrl_mode_q;
	logic [1:0] boost_output_range_q;
	logic       boost_feedback_select_q;
	logic       boost_sleep_enable_q;
	logic       unlocked_q;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			boost_fault_action_q    <= blrc_pkg::ACT_IGNORE;
			boost_hw_ctrl_source_q  <= 2'h0;
			boost_hw_ctrl_mode_q    <= blrc_pkg::RST_B_MODE;
			boost_output_range_q    <= blrc_pkg::RST_RANGE;
			boost_feedback_select_q <= 1'b0;
		end else if (wr_boost) begin
			boost_fault_action_q    <= hwdata[blrc_pkg::F_ACT_LO +: 2];
			boost_hw_ctrl_source_q  <= hwdata[blrc_pkg::F_SRC_LO +: 2];
			boost_hw_ctrl_mode_q    <= hwdata[blrc_pkg::F_B_MODE];
			boost_feedback_select_q <= hwdata[blrc_pkg::F_FB];
			if (unlocked_q && hwdata[blrc_pkg::F_RANGE +: 2] != blrc_pkg::RANGE_RSVD) begin
				boost_output_range_q <= hwdata[blrc_pkg::F_RANGE +: 2];
			end
		end
	end
	// unlock holds until the next boost control write or a security write without the key
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			unlocked_q <= 1'b0;
		end else if (wr_sec) begin
			unlocked_q <= (hwdata[15:0] == blrc_pkg::USER_KEY);
		end else if (wr_boost) begin
			unlocked_q <= 1'b0;
		end
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			boost_sleep_enable_q <= 1'b0;
		end else if (wr_sleep) begin
			boost_sleep_enable_q <= hwdata[blrc_pkg::F_SLPENA];
		end
	end
	// ==============================================
	// regulator one control fields
	logic [1:0] reg1_fault_action_q;
	logic [1:0] reg1_hw_ctrl_source_q;
	logic       reg1_hw_voltage_choice_q;
	logic [1:0] reg1_hw_ctrl_mode_q;
	logic       reg1_output_float_q;
	logic       reg1_switch_select_q;
	logic       reg1_low_power_level_q;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			reg1_fault_action_q      <= blrc_pkg::ACT_IGNORE;
			reg1_hw_ctrl_source_q    <= 2'h0;
			reg1_hw_voltage_choice_q <= 1'b0;
			reg1_hw_ctrl_mode_q      <= blrc_pkg::RST_R_MODE;
			reg1_output_float_q      <= 1'b0;
			reg1_switch_select_q     <= 1'b0;
			reg1_low_power_level_q   <= 1'b0;
		end else if (wr_reg1) begin
			reg1_fault_action_q      <= hwdata[blrc_pkg::F_ACT_LO +: 2];
			reg1_hw_ctrl_source_q    <= hwdata[blrc_pkg::F_SRC_LO +: 2];
			reg1_hw_voltage_choice_q <= hwdata[blrc_pkg::F_VCHOICE];
			reg1_hw_ctrl_mode_q      <= hwdata[blrc_pkg::F_R_MODE +: 2];
			reg1_output_float_q      <= hwdata[blrc_pkg::F_FLOAT];
			reg1_switch_select_q     <= hwdata[blrc_pkg::F_SWITCH];
			reg1_low_power_level_q   <= hwdata[blrc_pkg::F_LPLVL];
		end
	end
	// ==============================================
	// enables, on-state and sleep voltage settings
	logic       boost_enable_bit_q;
	logic       reg1_enable_q;
	logic       reg1_on_op_mode_q;
	logic [4:0] reg1_on_voltage_q;
	logic [4:0] reg1_sleep_voltage_q;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			boost_enable_bit_q   <= 1'b0;
			reg1_enable_q        <= 1'b0;
			reg1_on_op_mode_q    <= 1'b0;
			reg1_on_voltage_q    <= 5'h00;
			reg1_sleep_voltage_q <= 5'h00;
		end else if (wr_aux) begin
			boost_enable_bit_q   <= hwdata[blrc_pkg::F_B_EN];
			reg1_enable_q        <= hwdata[blrc_pkg::F_R_EN];
			reg1_on_op_mode_q    <= hwdata[blrc_pkg::F_ONMODE];
			reg1_on_voltage_q    <= hwdata[blrc_pkg::F_ONV_LO +: 5];
			reg1_sleep_voltage_q <= hwdata[blrc_pkg::F_SLV_LO +: 5];
		end
	end
	// ==============================================
	// fault actions; shutdown latches clear when the enable is dropped
	logic boost_shut_q;
	logic reg1_shut_q;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			boost_shut_q <= 1'b0;
		end else if (boost_uv_rise && boost_fault_action_q == blrc_pkg::ACT_SHUTDOWN) begin
			boost_shut_q <= 1'b1;
		end else if (!boost_enable_bit_q) begin
			boost_shut_q <= 1'b0;
		end
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			reg1_shut_q <= 1'b0;
		end else if (reg1_uv_rise && reg1_fault_action_q == blrc_pkg::ACT_SHUTDOWN) begin
			reg1_shut_q <= 1'b1;
		end else if (!reg1_enable_q) begin
			reg1_shut_q <= 1'b0;
		end
	end
	// reserved action code 11 falls through as ignore
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			device_reset_req <= 1'b0;
		end else begin
			device_reset_req <= (boost_uv_rise && boost_fault_action_q == blrc_pkg::ACT_RESET)
				|| (reg1_uv_rise && reg1_fault_action_q == blrc_pkg::ACT_RESET);
		end
	end
	// ==============================================
	// interrupt status, mask, line
	logic [1:0] status_q;
	logic [1:0] mask_q;
	logic [1:0] events;
	assign events = {reg1_uv_rise, boost_uv_rise};
	// set wins over write-one-to-clear
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			status_q <= 2'h0;
		end else begin
			status_q <= (status_q & ~(wr_stat ? hwdata[1:0] : 2'h0)) | events;
		end
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mask_q <= 2'h0;
		end else if (wr_mask) begin
			mask_q <= hwdata[1:0];
		end
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status_q & mask_q);
		end
	end
	// ==============================================
	// converter and regulator control outputs
	logic boost_hw;
	logic reg1_hw;
	assign boost_hw = src_active(boost_hw_ctrl_source_q, hw_one, hw_two);
	assign reg1_hw  = src_active(reg1_hw_ctrl_source_q, hw_one, hw_two);
	logic reg1_on_d;
	assign reg1_on_d = reg1_enable_q & ~reg1_shut_q & ~(reg1_hw & (reg1_hw_ctrl_mode_q == blrc_pkg::RMODE_OFF));
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			boost_on                <= 1'b0;
			boost_feedback_sink_two <= 1'b0;
			boost_range             <= blrc_pkg::RST_RANGE;
		end else begin
			boost_on <= boost_enable_bit_q & ~boost_shut_q
				& ~(boost_hw_ctrl_mode_q & boost_hw)
				& ~(in_sleep & ~boost_sleep_enable_q);
			boost_feedback_sink_two <= boost_feedback_select_q;
			boost_range             <= boost_output_range_q;
		end
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			reg1_on             <= 1'b0;
			reg1_low_power      <= 1'b1;
			reg1_vsel           <= 5'h00;
			reg1_discharge      <= 1'b1;
			reg1_switch_mode    <= 1'b0;
			reg1_low_power_20ma <= 1'b0;
		end else begin
			reg1_on <= reg1_on_d;
			if (reg1_hw) begin
				reg1_low_power <= (reg1_hw_ctrl_mode_q != blrc_pkg::RMODE_ONSET) | reg1_on_op_mode_q;
				reg1_vsel      <= reg1_hw_voltage_choice_q ? reg1_sleep_voltage_q : reg1_on_voltage_q;
			end else begin
				reg1_low_power <= reg1_on_op_mode_q;
				reg1_vsel      <= reg1_on_voltage_q;
			end
			reg1_discharge      <= ~reg1_on_d & ~reg1_output_float_q;
			reg1_switch_mode    <= reg1_switch_select_q;
			reg1_low_power_20ma <= reg1_low_power_level_q;
		end
	end
	// ==============================================
	// read data, loaded during the wait state
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (addr_q == byte_addr(blrc_pkg::IDX_BOOST_CTRL)) begin
			rd_mux[blrc_pkg::F_ACT_LO +: 2] = boost_fault_action_q;
			rd_mux[blrc_pkg::F_SRC_LO +: 2] = boost_hw_ctrl_source_q;
			rd_mux[blrc_pkg::F_B_MODE]      = boost_hw_ctrl_mode_q;
			rd_mux[blrc_pkg::F_RANGE +: 2]  = boost_output_range_q;
			rd_mux[blrc_pkg::F_FB]          = boost_feedback_select_q;
		end else if (addr_q == byte_addr(blrc_pkg::IDX_BOOST_SLEEP)) begin
			rd_mux[blrc_pkg::F_SLPENA] = boost_sleep_enable_q;
		end else if (addr_q == byte_addr(blrc_pkg::IDX_REG1_CTRL)) begin
			rd_mux[blrc_pkg::F_ACT_LO +: 2] = reg1_fault_action_q;
			rd_mux[blrc_pkg::F_SRC_LO +: 2] = reg1_hw_ctrl_source_q;
			rd_mux[blrc_pkg::F_VCHOICE]     = reg1_hw_voltage_choice_q;
			rd_mux[blrc_pkg::F_R_MODE +: 2] = reg1_hw_ctrl_mode_q;
			rd_mux[blrc_pkg::F_FLOAT]       = reg1_output_float_q;
			rd_mux[blrc_pkg::F_SWITCH]      = reg1_switch_select_q;
			rd_mux[blrc_pkg::F_LPLVL]       = reg1_low_power_level_q;
		end else if (addr_q == byte_addr(blrc_pkg::IDX_SECURITY)) begin
			rd_mux[0] = unlocked_q;
		end else if (addr_q == byte_addr(blrc_pkg::IDX_AUX)) begin
			rd_mux[blrc_pkg::F_B_EN]         = boost_enable_bit_q;
			rd_mux[blrc_pkg::F_R_EN]         = reg1_enable_q;
			rd_mux[blrc_pkg::F_ONMODE]       = reg1_on_op_mode_q;
			rd_mux[blrc_pkg::F_ONV_LO +: 5]  = reg1_on_voltage_q;
			rd_mux[blrc_pkg::F_SLV_LO +: 5]  = reg1_sleep_voltage_q;
		end else if (addr_q == byte_addr(blrc_pkg::IDX_IRQ_STATUS)) begin
			rd_mux[1:0] = status_q;
		end else if (addr_q == byte_addr(blrc_pkg::IDX_IRQ_MASK)) begin
			rd_mux[1:0] = mask_q;
		end
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			hrdata <= 32'h0000_0000;
		end else if (rd_q) begin
			hrdata <= rd_mux;
		end
	end
endmodule
